// ==== core/pff_feature_word.sv ====
// Processor feature flag word: answers identification queries with capabilities
//
// Behaviour
// R01 - Leaf one query returns word in result D
// R02 - Each bit is one only if supported
// R03 - Bit 0: on-chip floating-point unit present
// R04 - Bit 1: virtual-8086 enhancements supported
// R05 - Bit 2: debug extensions, I/O breakpoints
// R06 - Bit 3: large 4-Mbyte page support
// R07 - Bit 4: read stamp counter operation supported
// R08 - Bit 5: model-specific register access ops
// R09 - Bit 6: physical addresses wider than 32
// R10 - Wide addressing gives 36 address bits
// R11 - Bit 7: machine-check exception enable exists
// R12 - Bit 8: eight-byte compare exchange supported
// R13 - Bit 9: interrupt controller present and enabled
// R14 - Bit 12: memory type range registers
// R15 - Bit 13: global page enable exists
// R16 - Bit 14: machine check capability register
// R17 - Bit 15: conditional move, floating with FP unit
// R18 - Software checks vendor before reading bits
// R19 - Reserved bits 10, 11, 16-31 read zero
`timescale 1ns/1ns
module pff_feature_word
   import pff_pkg::*;
(
   // Clock, reset and enable
   input  wire logic                                  clk_i,
   input  wire logic                                  arst_n_i,
   input  wire logic                                  ce_i,
   // Identification query from the execution core
   input  wire logic                                  query_valid_i,
   input  wire logic      [pff_pkg::PFF_WORD_W-1:0]   query_leaf_i,
   output logic                                       query_ready_o,
   // Result register D and its qualifiers
   output logic                                       result_valid_o,
   output logic           [pff_pkg::PFF_WORD_W-1:0]   result_register_d_o,
   output logic                                       leaf_hit_o,
   // Board strap: floating-point unit fitted
   input  wire logic                                  float_strap_i,
   // Core-side state on the same clock
   input  wire logic                                  intc_enabled_i,
   input  wire logic                                  wide_addr_enable_i,
   // Derived capability outputs
   output logic           [pff_pkg::PFF_AWIDTH_W-1:0] phys_addr_width_o,
   output logic                                       fp_cond_move_o
);

   // ==========================================================================
   // Helper functions
   // ==========================================================================
   // True when the query carries the given identification input value.
   // Used both for the hit flag and for steering the result word.
   function automatic logic pff_leaf_is(input logic [PFF_WORD_W-1:0] leaf,
                                        input logic [PFF_WORD_W-1:0] value);
      pff_leaf_is = (leaf == value);
   endfunction

   // ==========================================================================
   // Strap synchroniser
   // ==========================================================================
   // The strap comes straight from a board pin, so it crosses two stages
   // before the capture logic looks at it.
   logic float_strap_sync;  // Strap after two stages

   pff_sync2 u_strap_sync (
      .clk_i    (clk_i),
      .arst_n_i (arst_n_i),
      .ce_i     (ce_i),
      .async_i  (float_strap_i),
      .sync_o   (float_strap_sync)
   );

   // ==========================================================================
   // Start-up sequencer state
   // ==========================================================================
   pff_state_t              state;             // Current start-up state
   pff_state_t              next_state;        // Next start-up state
   logic [PFF_SETTLE_W-1:0] settle_cnt;        // Cycles left before capture
   logic [PFF_SETTLE_W-1:0] next_settle_cnt;   // Next settle count
   logic                    fp_present;        // Strap caught after release
   logic                    next_fp_present;   // Next captured strap

   // Next start-up values.
   // The strap cannot be caught under reset (reset loads constants only),
   // so it is sampled once the synchroniser has had time to fill with the
   // pin level after the release. Queries wait until then; the cost is a
   // few cycles of latency after every reset, traded for a stable word.
   always_comb begin
      next_state       = state;
      next_settle_cnt  = settle_cnt;
      next_fp_present  = fp_present;
      if (ce_i) begin
         unique case (state)
            // Let the synchroniser fill with the real pin level
            PFF_ST_SETTLE: begin
               if (settle_cnt == PFF_SETTLE_ZERO) begin
                  next_state = PFF_ST_CAPTURE;
               end else begin
                  next_settle_cnt = settle_cnt - PFF_SETTLE_ONE;
               end
            end
            // Latch the strap once; it is not re-read until next reset
            PFF_ST_CAPTURE: begin
               next_fp_present  = float_strap_sync;  // [R03]
               next_state       = PFF_ST_READY;
            end
            // Serving queries; stays here until reset
            PFF_ST_READY: begin
               next_state = PFF_ST_READY;
            end
            // Illegal code on the two state bits: restart the sequence
            default: begin
               next_state      = PFF_ST_SETTLE;
               next_settle_cnt = PFF_SETTLE_CYCLES;
            end
         endcase
      end
   end

   // Start-up registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state       <= PFF_ST_SETTLE;
         settle_cnt  <= PFF_SETTLE_CYCLES;
         fp_present  <= 1'b0;
      end else begin
         state       <= next_state;
         settle_cnt  <= next_settle_cnt;
         fp_present  <= next_fp_present;
      end
   end

   // Queries are accepted only once the strap has been captured
   assign query_ready_o = (state == PFF_ST_READY);

   // ==========================================================================
   // Feature vector
   // ==========================================================================
   logic [PFF_FEAT_W-1:0] feat;        // Feature presence by bit position
   logic [PFF_WORD_W-1:0] cap_word;    // Packed capability word
   logic                  fp_move;     // Floating conditional move present

   // Each position is set exactly when the feature is really there.
   // Most features are fixed in silicon; bit 0 follows the captured
   // strap and the interrupt controller follows its live enable, because
   // a disabled controller must not be reported as usable.
   always_comb begin
      feat = '0;
      feat[PFF_BIT_FLOATING_POINT_PRESENT]      = fp_present;                           // [R03]
      feat[PFF_BIT_V86_ENHANCEMENTS]            = PFF_IMPL_V86_ENHANCEMENTS;            // [R04]
      feat[PFF_BIT_DEBUG_EXTENSIONS]            = PFF_IMPL_DEBUG_EXTENSIONS;            // [R05]
      feat[PFF_BIT_LARGE_PAGE_SUPPORT]          = PFF_IMPL_LARGE_PAGE_SUPPORT;          // [R06]
      feat[PFF_BIT_CYCLE_STAMP_COUNTER]         = PFF_IMPL_CYCLE_STAMP_COUNTER;         // [R07]
      feat[PFF_BIT_MODEL_SPECIFIC_REGS]         = PFF_IMPL_MODEL_SPECIFIC_REGS;         // [R08]
      feat[PFF_BIT_WIDE_PHYSICAL_ADDRESS]       = PFF_IMPL_WIDE_PHYSICAL_ADDRESS;       // [R09]
      feat[PFF_BIT_MACHINE_CHECK_EXCEPTION]     = PFF_IMPL_MACHINE_CHECK_EXCEPTION;     // [R11]
      feat[PFF_BIT_EIGHT_BYTE_COMPARE_EXCHANGE] = PFF_IMPL_EIGHT_BYTE_COMPARE_EXCHANGE; // [R12]
      feat[PFF_BIT_ONCHIP_INTERRUPT_CONTROLLER] =
         PFF_IMPL_ONCHIP_INTERRUPT_CONTROLLER & intc_enabled_i;                        // [R13]
      feat[PFF_BIT_RESERVED_A]                  = 1'b0;                                 // [R19]
      feat[PFF_BIT_RESERVED_B]                  = 1'b0;                                 // [R19]
      feat[PFF_BIT_MEMORY_TYPE_RANGES]          = PFF_IMPL_MEMORY_TYPE_RANGES;          // [R14]
      feat[PFF_BIT_GLOBAL_PAGE_ENABLE]          = PFF_IMPL_GLOBAL_PAGE_ENABLE;          // [R15]
      feat[PFF_BIT_MACHINE_CHECK_ARCHITECTURE]  = PFF_IMPL_MACHINE_CHECK_ARCHITECTURE;  // [R16]
      feat[PFF_BIT_CONDITIONAL_MOVE]            = PFF_IMPL_CONDITIONAL_MOVE;            // [R17]
   end

   // Packing also forces the upper half and the reserved pair to zero
   pff_word_pack u_pack (
      .feat_i         (feat),
      .word_o         (cap_word),
      .fp_cond_move_o (fp_move)
   );

   // ==========================================================================
   // Query answer state
   // ==========================================================================
   logic                  query_take;       // Query accepted this cycle
   logic                  leaf_match;       // Query selects the feature word
   logic                  next_result_valid;
   logic [PFF_WORD_W-1:0] next_result_d;
   logic                  next_leaf_hit;

   assign query_take = ce_i & query_valid_i & query_ready_o;
   assign leaf_match = pff_leaf_is(query_leaf_i, PFF_LEAF_FEATURES);

   // Next answer values.
   // Only the feature leaf is answered here; any other leaf returns a zero
   // word with the hit flag low, so the core can merge in the version,
   // vendor and cache leaves from elsewhere. The word is snapshot at the
   // query, so a later change of the controller enable does not alter an
   // answer already given.
   always_comb begin
      next_result_valid = 1'b0;
      next_result_d     = result_register_d_o;
      next_leaf_hit     = leaf_hit_o;
      if (!ce_i) begin
         // Frozen: hold the valid pulse as it stands
         next_result_valid = result_valid_o;
      end else if (query_take) begin
         next_result_valid = 1'b1;
         next_leaf_hit     = leaf_match;
         if (leaf_match) begin
            next_result_d = cap_word;  // [R01]
         end else begin
            next_result_d = PFF_WORD_ZERO;
         end
      end
   end

   // Answer registers; the data holds until the next query
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         result_valid_o      <= 1'b0;
         result_register_d_o <= PFF_WORD_ZERO;
         leaf_hit_o          <= 1'b0;
      end else begin
         result_valid_o      <= next_result_valid;
         result_register_d_o <= next_result_d;
         leaf_hit_o          <= next_leaf_hit;
      end
   end

   // ==========================================================================
   // Derived capability state
   // ==========================================================================
   logic [PFF_AWIDTH_W-1:0] next_awidth;   // Next address width
   logic                    next_fp_move;  // Next floating move flag

   // Address width follows the wide-address control bit; without that
   // bit, or on a build without the extension, the base width applies.
   always_comb begin
      next_awidth  = phys_addr_width_o;
      next_fp_move = fp_cond_move_o;
      if (ce_i) begin
         if (wide_addr_enable_i && PFF_IMPL_WIDE_PHYSICAL_ADDRESS) begin
            next_awidth = PFF_AWIDTH_WIDE;  // [R10]
         end else begin
            next_awidth = PFF_AWIDTH_BASE;
         end
         next_fp_move = fp_move;  // [R17]
      end
   end

   // Derived capability registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         phys_addr_width_o <= PFF_AWIDTH_BASE;
         fp_cond_move_o    <= 1'b0;
      end else begin
         phys_addr_width_o <= next_awidth;
         fp_cond_move_o    <= next_fp_move;
      end
   end

endmodule

// ==== core/pff_pkg.sv ====
// Constants shared by the processor feature flag word block
package pff_pkg;

   // ==========================================================================
   // Query and result widths
   // ==========================================================================
   localparam int unsigned PFF_WORD_W   = 32;  // Result register width
   localparam int unsigned PFF_FEAT_W   = 16;  // Defined feature positions 15..0
   localparam int unsigned PFF_AWIDTH_W = 6;   // Physical address width field

   // Identification input value that selects the feature word
   localparam logic [PFF_WORD_W-1:0] PFF_LEAF_FEATURES = 32'h0000_0001;

   // Result seen on any leaf this block does not answer
   localparam logic [PFF_WORD_W-1:0] PFF_WORD_ZERO = 32'h0000_0000;

   // ==========================================================================
   // Bit positions inside the capability word
   // ==========================================================================
   localparam int unsigned PFF_BIT_FLOATING_POINT_PRESENT      = 0;
   localparam int unsigned PFF_BIT_V86_ENHANCEMENTS            = 1;
   localparam int unsigned PFF_BIT_DEBUG_EXTENSIONS            = 2;
   localparam int unsigned PFF_BIT_LARGE_PAGE_SUPPORT          = 3;
   localparam int unsigned PFF_BIT_CYCLE_STAMP_COUNTER         = 4;
   localparam int unsigned PFF_BIT_MODEL_SPECIFIC_REGS         = 5;
   localparam int unsigned PFF_BIT_WIDE_PHYSICAL_ADDRESS       = 6;
   localparam int unsigned PFF_BIT_MACHINE_CHECK_EXCEPTION     = 7;
   localparam int unsigned PFF_BIT_EIGHT_BYTE_COMPARE_EXCHANGE = 8;
   localparam int unsigned PFF_BIT_ONCHIP_INTERRUPT_CONTROLLER = 9;
   localparam int unsigned PFF_BIT_RESERVED_A                  = 10;
   localparam int unsigned PFF_BIT_RESERVED_B                  = 11;
   localparam int unsigned PFF_BIT_MEMORY_TYPE_RANGES          = 12;
   localparam int unsigned PFF_BIT_GLOBAL_PAGE_ENABLE          = 13;
   localparam int unsigned PFF_BIT_MACHINE_CHECK_ARCHITECTURE  = 14;
   localparam int unsigned PFF_BIT_CONDITIONAL_MOVE            = 15;

   // ==========================================================================
   // Features this core implements in silicon (1 = built in)
   // ==========================================================================
   localparam logic PFF_IMPL_V86_ENHANCEMENTS            = 1'b1;
   localparam logic PFF_IMPL_DEBUG_EXTENSIONS            = 1'b1;
   localparam logic PFF_IMPL_LARGE_PAGE_SUPPORT          = 1'b1;
   localparam logic PFF_IMPL_CYCLE_STAMP_COUNTER         = 1'b1;
   localparam logic PFF_IMPL_MODEL_SPECIFIC_REGS         = 1'b1;
   localparam logic PFF_IMPL_WIDE_PHYSICAL_ADDRESS       = 1'b1;
   localparam logic PFF_IMPL_MACHINE_CHECK_EXCEPTION     = 1'b1;
   localparam logic PFF_IMPL_EIGHT_BYTE_COMPARE_EXCHANGE = 1'b1;
   localparam logic PFF_IMPL_ONCHIP_INTERRUPT_CONTROLLER = 1'b1;
   localparam logic PFF_IMPL_MEMORY_TYPE_RANGES          = 1'b1;
   localparam logic PFF_IMPL_GLOBAL_PAGE_ENABLE          = 1'b1;
   localparam logic PFF_IMPL_MACHINE_CHECK_ARCHITECTURE  = 1'b1;
   localparam logic PFF_IMPL_CONDITIONAL_MOVE            = 1'b1;

   // ==========================================================================
   // Physical address widths
   // ==========================================================================
   localparam logic [PFF_AWIDTH_W-1:0] PFF_AWIDTH_BASE = 6'h20;  // 32 bits
   localparam logic [PFF_AWIDTH_W-1:0] PFF_AWIDTH_WIDE = 6'h24;  // 36 bits

   // ==========================================================================
   // Start-up sequencing
   // ==========================================================================
   localparam int unsigned             PFF_SETTLE_W      = 2;
   localparam logic [PFF_SETTLE_W-1:0] PFF_SETTLE_CYCLES = 2'h2;  // Synchroniser depth
   localparam logic [PFF_SETTLE_W-1:0] PFF_SETTLE_ZERO   = 2'h0;
   localparam logic [PFF_SETTLE_W-1:0] PFF_SETTLE_ONE    = 2'h1;

   // Start-up states, Gray coded along settle -> capture -> ready
   typedef enum logic [1:0] {
      PFF_ST_SETTLE  = 2'h0,
      PFF_ST_CAPTURE = 2'h1,
      PFF_ST_READY   = 2'h3
   } pff_state_t;

endpackage

// ==== core/pff_sync2.sv ====
// Two-stage synchroniser for a level arriving from outside the clock domain
`timescale 1ns/1ns
module pff_sync2 (
   // Clock, reset and enable
   input  wire logic clk_i,
   input  wire logic arst_n_i,
   input  wire logic ce_i,
   // Level in and synchronised level out
   input  wire logic async_i,
   output logic      sync_o
);

   // ==========================================================================
   // Synchroniser stages
   // ==========================================================================
   logic meta;       // First stage, read only by the second stage
   logic next_meta;  // Next value of the first stage
   logic next_sync;  // Next value of the second stage

   // Next values; both stages hold while the enable is low
   always_comb begin
      next_meta = meta;
      next_sync = sync_o;
      if (ce_i) begin
         next_meta = async_i;
         next_sync = meta;
      end
   end

   // Stage registers
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta   <= next_meta;
         sync_o <= next_sync;
      end
   end

endmodule

// ==== core/pff_word_pack.sv ====
// Packs the feature vector into the 32-bit capability word
`timescale 1ns/1ns
module pff_word_pack
   import pff_pkg::*;
(
   // Feature presence, one bit per defined position
   input  wire logic [pff_pkg::PFF_FEAT_W-1:0] feat_i,
   // Assembled capability word
   output logic      [pff_pkg::PFF_WORD_W-1:0] word_o,
   // Floating conditional move and ordered compare available
   output logic                                fp_cond_move_o
);

   // ==========================================================================
   // Word assembly
   // ==========================================================================
   // Defined positions copy straight through; everything else stays zero
   always_comb begin
      word_o = PFF_WORD_ZERO;
      word_o[PFF_FEAT_W-1:0] = feat_i;                      // [R02]
      word_o[PFF_BIT_RESERVED_A] = 1'b0;                    // [R19]
      word_o[PFF_BIT_RESERVED_B] = 1'b0;                    // [R19]
   end

   // Floating variants only exist when the floating-point unit is there as well
   assign fp_cond_move_o = feat_i[PFF_BIT_CONDITIONAL_MOVE]
                         & feat_i[PFF_BIT_FLOATING_POINT_PRESENT];  // [R17]

endmodule

// ==== tb/pff_feature_word_checker.sv ====
// Concurrent checks on the ports of the processor feature flag word block
`timescale 1ns/1ns
module pff_feature_word_checker
   import pff_pkg::*;
(
   // Clock, reset and enable
   input wire logic                            clk_i,
   input wire logic                            arst_n_i,
   input wire logic                            ce_i,
   // Query and answer
   input wire logic                            query_valid_i,
   input wire logic [pff_pkg::PFF_WORD_W-1:0]  query_leaf_i,
   input wire logic                            query_ready_o,
   input wire logic                            result_valid_o,
   input wire logic [pff_pkg::PFF_WORD_W-1:0]  result_register_d_o,
   input wire logic                            leaf_hit_o,
   // Side inputs and derived outputs
   input wire logic                            intc_enabled_i,
   input wire logic                            wide_addr_enable_i,
   input wire logic [pff_pkg::PFF_AWIDTH_W-1:0] phys_addr_width_o,
   input wire logic                            fp_cond_move_o
);
   // ==========================================================================
   // Sequences of a query
   // ==========================================================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // A query taken on an enabled edge
   sequence s_take;
      ce_i && query_valid_i && query_ready_o;
   endsequence
   // A taken query for the feature leaf
   sequence s_feat_take;
      s_take ##0 (query_leaf_i == PFF_LEAF_FEATURES);
   endsequence
   // Answer carrying every fixed built-in feature bit (1-8, 12-15); bit 9 is left to a_intc_live
   sequence s_feat_answer;
      result_valid_o && leaf_hit_o && (result_register_d_o[8:1] == 8'hFF) && (result_register_d_o[15:12] == 4'hF);
   endsequence

   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_answer_next: assert property (s_take |=> result_valid_o)
      else $error("answer pulse missing after taken query");
   a_no_spurious: assert property (ce_i && !(query_valid_i && query_ready_o) |=> !result_valid_o)
      else $error("answer pulse without a taken query");
   a_feature_ones: assert property (s_feat_take |=> s_feat_answer)
      else $error("built-in feature bit missing in answer");
   a_intc_live: assert property (s_feat_take |=> result_register_d_o[9] == $past(intc_enabled_i))
      else $error("interrupt controller bit does not follow its enable");
   a_other_zero: assert property (s_take ##0 (query_leaf_i != PFF_LEAF_FEATURES) |=>
                                  (result_register_d_o == PFF_WORD_ZERO) && !leaf_hit_o)
      else $error("other leaf answered with nonzero word");
   a_reserved_zero: assert property ((result_register_d_o[11:10] == 2'h0) && (result_register_d_o[31:16] == 16'h0))
      else $error("reserved bit set in answer");
   a_width_select: assert property (ce_i |=> phys_addr_width_o ==
                                    ($past(wide_addr_enable_i) ? PFF_AWIDTH_WIDE : PFF_AWIDTH_BASE))
      else $error("address width does not follow wide enable");
   a_fp_cond_move: assert property (result_valid_o && leaf_hit_o |-> fp_cond_move_o == result_register_d_o[0])
      else $error("floating conditional move flag disagrees with bit 0");
   a_hold_data: assert property (ce_i && !(query_valid_i && query_ready_o) |=>
                                 $stable(result_register_d_o) && $stable(leaf_hit_o))
      else $error("answer word changed without a query");
   a_ready_stays: assert property (query_ready_o |=> query_ready_o)
      else $error("ready dropped outside reset");
endmodule

bind pff_feature_word pff_feature_word_checker u_chk (
   .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .query_valid_i(query_valid_i),
   .query_leaf_i(query_leaf_i), .query_ready_o(query_ready_o), .result_valid_o(result_valid_o),
   .result_register_d_o(result_register_d_o), .leaf_hit_o(leaf_hit_o), .intc_enabled_i(intc_enabled_i),
   .wide_addr_enable_i(wide_addr_enable_i), .phys_addr_width_o(phys_addr_width_o),
   .fp_cond_move_o(fp_cond_move_o));

// ==== tb/tb_pff_feature_word.sv ====
// Self-checking testbench for the processor feature flag word block
`timescale 1ns/1ns
module tb_pff_feature_word;
   import pff_pkg::*;
   // ==========================================================================
   // Signals and counters
   // ==========================================================================
   logic                    clk_i, arst_n_i, ce_i, query_valid_i, float_strap_i, intc_enabled_i, wide_addr_enable_i;
   logic                    query_ready_o, result_valid_o, leaf_hit_o, fp_cond_move_o;
   logic [PFF_WORD_W-1:0]   query_leaf_i, result_register_d_o;
   logic [PFF_AWIDTH_W-1:0] phys_addr_width_o;
   int                      n_fail = 0;
   int                      checks = 0;
   int                      cycles = 0;

   pff_feature_word dut (
      .clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .query_valid_i(query_valid_i),
      .query_leaf_i(query_leaf_i), .query_ready_o(query_ready_o), .result_valid_o(result_valid_o),
      .result_register_d_o(result_register_d_o), .leaf_hit_o(leaf_hit_o), .float_strap_i(float_strap_i),
      .intc_enabled_i(intc_enabled_i), .wide_addr_enable_i(wide_addr_enable_i),
      .phys_addr_width_o(phys_addr_width_o), .fp_cond_move_o(fp_cond_move_o));

   // ==========================================================================
   // Clock, timeout and helpers
   // ==========================================================================
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // Whole run needs well under 200 cycles; the ceiling leaves ample slack
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         results();
      end
   end

   // Expected feature word: all built-in bits, strap on bit 0, live enable on bit 9
   function automatic logic [31:0] exp_word(input logic strap, input logic intc);
      return 32'h0000_F1FE | {22'h0, intc, 8'h00, strap};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask

   // Inputs change one nanosecond after the edge; outputs are settled by then
   task automatic step();
      @(posedge clk_i);
      #1;
   endtask

   // Hold reset 16 cycles, check reset values, release just after an edge
   task automatic reset_dut(input logic strap);
      arst_n_i = 1'b0;
      float_strap_i = strap;
      repeat (16) step();
      check(32'(query_ready_o), 32'h0);
      check(result_register_d_o, PFF_WORD_ZERO);
      check(32'(phys_addr_width_o), 32'h20);
      arst_n_i = 1'b1;
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   // Early query refused until ready, then answered with the full word
   task automatic t_startup();
      query_valid_i = 1'b1;
      query_leaf_i = PFF_LEAF_FEATURES;
      reset_dut(1'b1);
      for (int i = 1; i <= 4; i++) begin
         step();
         check(32'(query_ready_o), 32'(i == 4));
         check(32'(result_valid_o), 32'h0);
      end
      step();
      check(32'(result_valid_o), 32'h1);
      check(result_register_d_o, exp_word(1'b1, 1'b1));
      check(32'(fp_cond_move_o), 32'h1);
      query_valid_i = 1'b0;
      step();
      check(32'(result_valid_o), 32'h0);
      $display("t_startup done");
   endtask

   // Back-to-back queries over several leaves with the controller enable toggling
   task automatic t_leaves();
      logic [31:0] leaf [6] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h1, 32'hFFFF_FFFF}; // Vendor leaf first
      query_valid_i = 1'b1;
      foreach (leaf[k]) begin
         query_leaf_i = leaf[k];
         intc_enabled_i = k[0];
         step();
         check(32'(result_valid_o), 32'h1);
         check(result_register_d_o, (leaf[k] == PFF_LEAF_FEATURES) ? exp_word(1'b1, k[0]) : PFF_WORD_ZERO);
         check(32'(leaf_hit_o), 32'(leaf[k] == PFF_LEAF_FEATURES));
      end
      query_valid_i = 1'b0;
      step();
      check(32'(result_valid_o), 32'h0);
      $display("t_leaves done");
   endtask

   // Enable low freezes the block: no answer, word held
   task automatic t_freeze();
      ce_i = 1'b0;
      query_valid_i = 1'b1;
      query_leaf_i = PFF_LEAF_FEATURES;
      intc_enabled_i = 1'b0;
      repeat (3) begin
         step();
         check(32'(result_valid_o), 32'h0);
         check(result_register_d_o, PFF_WORD_ZERO);
      end
      ce_i = 1'b1;
      step();
      query_valid_i = 1'b0;
      check(result_register_d_o, exp_word(1'b1, 1'b0));
      $display("t_freeze done");
   endtask

   // Address width follows the wide enable one edge later
   task automatic t_width();
      for (int w = 1; w >= 0; w--) begin
         wide_addr_enable_i = w[0];
         step();
         check(32'(phys_addr_width_o), w[0] ? 32'h24 : 32'h20);
      end
      $display("t_width done");
   endtask

   // Second reset with no floating-point unit fitted and controller disabled
   task automatic t_no_float();
      intc_enabled_i = 1'b0;
      query_valid_i = 1'b1;
      reset_dut(1'b0);
      repeat (5) step();
      query_valid_i = 1'b0;
      check(32'(result_valid_o), 32'h1);
      check(result_register_d_o, exp_word(1'b0, 1'b0));
      check(32'(fp_cond_move_o), 32'h0);
      $display("t_no_float done");
   endtask

   // ==========================================================================
   // Closing report and main sequence
   // ==========================================================================
   task automatic results();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      arst_n_i = 1'b0;
      ce_i = 1'b1;
      query_valid_i = 1'b0;
      query_leaf_i = PFF_WORD_ZERO;
      float_strap_i = 1'b1;
      intc_enabled_i = 1'b1;
      wide_addr_enable_i = 1'b0;
      t_startup();
      t_leaves();
      t_freeze();
      t_width();
      t_no_float();
      results();
   end
endmodule
